// ### fractional_synth_control_test.sv
// fractional_synth_control_test: self-checking bench for synth_ctrl
// assumes synth_pkg, loop_front_model and the bound checker compiled first
`timescale 1ns/1ps
module fractional_synth_control_test;
  import synth_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic chip_en = 1'b0;
  logic phase_err_valid = 1'b0;
  logic [7:0] phase_err_cycles = 8'h00;
  logic transmit_bit_input = 1'b0;
  logic [31:0] prdata, q;
  logic pready, pslverr, xtal_tick, vco_tick, ref_clk_pulse, fb_clk_pulse, e;
  logic vco_enable, band_halving_bit, amp_enable_bit, regulators_on;
  logic status_mux_output_o, status_mux_output_oe;
  logic [3:0] vco_bias;
  logic [1:0] vco_adjust, pa_bias;
  logic [5:0] pa_power;
  int miscompares = 0;
  int compares = 0;
  int r, f;
  // pin level: driven while oe is low, the pull-up holds it high when released
  wire mux_wire = status_mux_output_oe ? 1'b1 : status_mux_output_o;
  row_s rows [6] = '{'{ADDR_DIVIDE, 32'h1005_1234, 32'h101f_1234},
    '{ADDR_DIVIDE, 32'h30ff_7fff, 32'h30ff_3fff},
    '{ADDR_OSC, 32'h003c_2000, 32'h003c_2001},
    '{ADDR_OSC, 32'h000c_0003, 32'h000c_0003},
    '{ADDR_TX, 32'hc0ff_fe10, 32'hc0ff_fe10},
    '{ADDR_TX, 32'h0000_0e00, 32'h0000_0e00}};
  // ============================================================
  // clock and instances
  always #25 pclk = ~pclk;
  synth_ctrl #(.REG_READY_CYCLES(8)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .chip_en, .xtal_tick, .vco_tick, .phase_err_valid,
    .phase_err_cycles, .transmit_bit_input, .ref_clk_pulse, .fb_clk_pulse, .vco_enable,
    .band_halving_bit, .vco_bias, .vco_adjust, .amp_enable_bit, .pa_power, .pa_bias,
    .regulators_on, .status_mux_output_o, .status_mux_output_oe);
  loop_front_model u_model (.pclk, .presetn, .vco_enable, .xtal_tick, .vco_tick);
  // ============================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic complete_run;
    $display("counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      miscompares++;
      $display("[FAIL] pready expected 1 seen %b", pready);
      complete_run;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic cmp(input logic [7:0] w);
    phase_err_valid <= 1'b1;
    phase_err_cycles <= w;
    @(posedge pclk);
    phase_err_valid <= 1'b0;
    @(posedge pclk);
  endtask : cmp
  task automatic stat(input logic [31:0] exp);
    repeat (6) @(posedge pclk);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk("status", exp, q);
  endtask : stat
  // restart the loop from a cleared divider, then count reference and feedback pulses
  task automatic run_fb(input logic [31:0] d, input int n);
    apb(ADDR_DIVIDE, 1'b1, {d[31:29], 1'b0, d[27:0]});
    apb(ADDR_DIVIDE, 1'b1, d);
    r = 0;
    f = 0;
    repeat (n) begin
      @(posedge pclk);
      r += int'(ref_clk_pulse === 1'b1);
      f += int'(fb_clk_pulse === 1'b1);
    end
  endtask : run_fb
  // ============================================================
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(ADDR_TX, 1'b1, 32'hffff_ffff);
    apb(ADDR_TX, 1'b0, 32'h0);
    chk("tx refused", TX_RESET, q);
    apb(ADDR_DIVIDE, 1'b0, 32'h0);
    chk("divide reset", DIVIDE_RESET, q);
    apb(ADDR_OSC, 1'b0, 32'h0);
    chk("osc reset", OSC_RESET, q);
    $display("test reset done");
    chip_en <= 1'b1;
    q = 32'h0;
    for (int i = 0; i < 40 && q[0] !== 1'b1; i++) apb(ADDR_STATUS, 1'b0, 32'h0);
    chk("status ready", 32'h3, q);
    chk("mux ready", 32'h1, mux_wire);
    $display("test ready done");
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].d);
      apb(rows[i].a, 1'b0, 32'h0);
      chk("register row", rows[i].e, q);
    end
    apb(12'h010, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, e);
    $display("test registers done");
    run_fb(32'h101f_3fff, 1250);
    chk("ref count", 32'h1, r >= 208 && r <= 209);
    chk("fb count", 32'h28, f);
    $display("test dividers done");
    apb(ADDR_TX, 1'b1, 32'h00ff_8000);
    transmit_bit_input <= 1'b1;
    run_fb(32'h101f_0000, 4962);
    chk("fsk up count", 32'ha0, f);
    transmit_bit_input <= 1'b0;
    run_fb(32'h101f_0000, 4962);
    chk("fsk down count", 32'ha1, f);
    $display("test fsk done");
    apb(ADDR_DIVIDE, 1'b1, 32'h301f_0000);
    repeat (4) cmp(8'h00);
    cmp(8'h01);
    repeat (4) cmp(8'h00);
    stat(32'h3);
    chk("mux unlocked", 32'h0, mux_wire);
    cmp(8'h00);
    stat(32'h7);
    chk("mux locked", 32'h1, mux_wire);
    repeat (3) cmp(8'h00);
    apb(ADDR_DIVIDE, 1'b1, 32'h501f_0000);
    r = 0;
    repeat (20) begin
      @(posedge pclk);
      r += int'(mux_wire === 1'b1);
    end
    chk("analog high", 32'h1, r >= 15);
    cmp(8'h01);
    r = 0;
    repeat (4) begin
      @(posedge pclk);
      r += int'(mux_wire === 1'b0);
    end
    chk("analog low pulse", 32'h1, r);
    stat(32'h3);
    $display("test lock done");
    chip_en <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(ADDR_TX, 1'b0, 32'h0);
    chk("tx wiped", TX_RESET, q);
    apb(ADDR_DIVIDE, 1'b0, 32'h0);
    chk("divide wiped", DIVIDE_RESET, q);
    chk("regulators off", 32'h0, regulators_on);
    $display("test wipe done");
    complete_run;
  end
endmodule : fractional_synth_control_test

// ### loop_front_model.sv
// loop_front_model: crystal and oscillator tick source facing synth_ctrl
// assumes one pclk domain; crystal ticks are single-cycle pulses, vco_tick stays high every cycle while enabled
`timescale 1ns/1ps
module loop_front_model #(
  parameter int XTAL_DIV = 2
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic vco_enable, // loop enable from the block
  output logic xtal_tick, // one pulse per crystal cycle
  output logic vco_tick // one pulse per oscillator cycle
);
  int cnt_r;
  // ============================================================
  // crystal ticks every XTAL_DIV cycles; oscillator runs only when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 0;
      xtal_tick <= 1'b0;
      vco_tick <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == XTAL_DIV - 1) ? 0 : cnt_r + 1;
      xtal_tick <= (cnt_r == XTAL_DIV - 1);
      vco_tick <= vco_enable;
    end
  end
endmodule : loop_front_model

// ### sd_modulator.sv
// sd_modulator: first-order sigma-delta dithering of the integer modulus
// assumes a one-cycle advance pulse per feedback divider period
`timescale 1ns/1ps
module sd_modulator #(
  parameter int ACC_W = 15
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic clear, // synchronous wipe
  input wire logic advance, // one step per divider cycle
  input wire logic [ACC_W-1:0] frac, // fractional word
  output logic carry // add one to modulus this cycle
);
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W:0] sum;
  // accumulate the fraction; overflow selects modulus plus one
  assign sum = {1'b0, acc_r} + {1'b0, frac};
  assign carry = advance & sum[ACC_W];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= '0;
    end else if (clear) begin
      acc_r <= '0;
    end else if (advance) begin
      acc_r <= sum[ACC_W-1:0];
    end
  end
endmodule : sd_modulator

// ### synth_ctrl.sv
// synth_ctrl: register file, feedback divider, fsk offset and lock detect
// assumes apb master, chip enable and phase error comparator inputs sync to pclk
`timescale 1ns/1ps
module synth_ctrl
  import synth_pkg::*;
#(
  parameter int REG_READY_CYCLES = REG_READY_CYC,
  parameter int INT_W_P = 8
) (
  input wire logic pclk, // apb clock, 20 mhz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic chip_en, // chip enable, high active
  input wire logic xtal_tick, // one pulse per crystal cycle
  input wire logic vco_tick, // one pulse per vco feedback cycle
  input wire logic phase_err_valid, // comparison done this cycle
  input wire logic [7:0] phase_err_cycles, // error width in pclk cycles
  input wire logic transmit_bit_input, // fsk data bit
  output logic ref_clk_pulse, // phase comparator reference pulse
  output logic fb_clk_pulse, // feedback divider output pulse
  output logic vco_enable, // oscillator and loop on
  output logic band_halving_bit, // extra divide by two after loop
  output logic [3:0] vco_bias, // oscillator bias setting
  output logic [1:0] vco_adjust, // oscillator recenter
  output logic amp_enable_bit, // output stage on
  output logic [5:0] pa_power, // output power field
  output logic [1:0] pa_bias, // amplifier bias field
  output logic regulators_on, // regulators enabled
  output logic status_mux_output_o, // status mux level
  output logic status_mux_output_oe // output enable, low drives the pin
);
  // ============================================================
  // elaboration check
  if (INT_W_P != 8 || REG_READY_CYCLES < 1 || REG_READY_CYCLES > 65536) begin : g_bad
    $error("synth_ctrl: unsupported parameter");
  end

  typedef enum logic [1:0] {LK_IDLE, LK_COUNT, LK_LOCKED} lock_e;

  logic [31:0] divide_r;
  logic [31:0] osc_r;
  logic [31:0] tx_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [15:0] ready_cnt_r;
  logic reg_ready_r;
  logic [2:0] rcnt_r;
  logic ref_pulse_r;
  logic [23:0] ncnt_r;
  logic fb_pulse_r;
  lock_e lock_st_r;
  lock_e lock_st_nxt;
  logic [2:0] good_cnt_r;
  logic [2:0] good_cnt_nxt;
  logic dig_lock_r;
  logic ana_pulse_r;
  logic mux_r;
  logic mux_oe_r;
  logic [7:0] cfg_r_vco_bias;
  logic chip_en_r;

  // ============================================================
  // apb decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] base);
    hit = (a == base);
  endfunction : hit

  wire setup_ok = psel & ~penable;
  wire access = psel & penable;
  wire sel_div = hit(paddr, ADDR_DIVIDE);
  wire sel_osc = hit(paddr, ADDR_OSC);
  wire sel_tx = hit(paddr, ADDR_TX);
  wire sel_st = hit(paddr, ADDR_STATUS);
  wire mapped = sel_div | sel_osc | sel_tx | sel_st;
  // writes accepted only while chip enabled and regulator ready
  wire wr_ok = access & pwrite & chip_en & reg_ready_r;
  wire wr_div = wr_ok & sel_div;
  wire wr_osc = wr_ok & sel_osc;
  wire wr_tx = wr_ok & sel_tx;

  // integer field clamped to the pulse-swallow minimum
  wire [7:0] int_wr = pwdata[INT_LSB +: INT_W];
  wire [7:0] int_fix = (int_wr < INT_MIN) ? INT_MIN : int_wr;
  // fraction limited to 14 bits of resolution over 2^15
  wire [14:0] frac_wr = {1'b0, pwdata[FRAC_LSB +: FRAC_W-1]};
  wire [2:0] rdiv_wr = pwdata[RDIV_LSB +: RDIV_W];
  wire [2:0] rdiv_fix = (rdiv_wr == 3'h0) ? RDIV_RESET : rdiv_wr;

  wire [31:0] div_wdata = {pwdata[31:24], int_fix, pwdata[15], frac_wr};
  wire [31:0] osc_wdata = {pwdata[31:3], rdiv_fix};
  wire [31:0] status_word = {29'h0, dig_lock_r, chip_en, reg_ready_r};
  wire [31:0] rd_mux = sel_div ? divide_r :
                       sel_osc ? osc_r :
                       sel_tx ? tx_r :
                       sel_st ? status_word : 32'h0;

  // apb answer: ready in the access cycle, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= setup_ok;
      pslverr_r <= setup_ok & ~mapped;
      prdata_r <= (setup_ok & ~pwrite) ? rd_mux : 32'h0;
    end
  end
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
  wire access_done = access & pready_r;

  // configuration registers, wiped while chip enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divide_r <= DIVIDE_RESET;
      osc_r <= OSC_RESET;
      tx_r <= TX_RESET;
    end else if (!chip_en) begin
      divide_r <= DIVIDE_RESET;
      osc_r <= OSC_RESET;
      tx_r <= TX_RESET;
    end else if (access_done) begin
      if (wr_div) divide_r <= div_wdata;
      if (wr_osc) osc_r <= osc_wdata;
      if (wr_tx) tx_r <= pwdata;
    end
  end

  // ============================================================
  // regulator ready timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_cnt_r <= 16'h0;
      reg_ready_r <= 1'b0;
    end else if (!chip_en) begin
      ready_cnt_r <= 16'h0;
      reg_ready_r <= 1'b0;
    end else if (ready_cnt_r == 16'(REG_READY_CYCLES - 1)) begin
      reg_ready_r <= 1'b1;
    end else begin
      ready_cnt_r <= ready_cnt_r + 16'h1;
    end
  end

  // ============================================================
  // reference divider: one pulse per r crystal ticks
  wire [2:0] rdiv = osc_r[RDIV_LSB +: RDIV_W];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcnt_r <= 3'h0;
      ref_pulse_r <= 1'b0;
    end else if (!chip_en) begin
      rcnt_r <= 3'h0;
      ref_pulse_r <= 1'b0;
    end else begin
      ref_pulse_r <= 1'b0;
      if (xtal_tick) begin
        if (rcnt_r >= rdiv - 3'h1) begin
          rcnt_r <= 3'h0;
          ref_pulse_r <= 1'b1;
        end else begin
          rcnt_r <= rcnt_r + 3'h1;
        end
      end
    end
  end

  // ============================================================
  // feedback divider with fsk offset and sigma-delta dither
  wire synth_enable_bit = divide_r[SYNTH_EN_BIT];
  wire [7:0] int_n = divide_r[INT_LSB +: INT_W];
  wire [14:0] frac_n = divide_r[FRAC_LSB +: FRAC_W];
  wire [8:0] modnum = tx_r[MODNUM_LSB +: MODNUM_W];
  wire fsk_sel = (tx_r[MODSEL_LSB +: MODSEL_W] == MOD_FSK);
  // deviation modnum/2^14 equals 2*modnum/2^15 in divide units
  wire [23:0] centre = {1'b0, int_n, frac_n};
  wire [23:0] dev = {14'h0, modnum, 1'b0};
  wire [23:0] n_word = !fsk_sel ? centre :
                       transmit_bit_input ? centre + dev : centre - dev;
  wire [8:0] n_int = n_word[23:15];
  wire [14:0] n_frac = n_word[14:0];
  wire carry;
  wire fb_end = vco_tick & (ncnt_r[8:0] == 9'h0);
  wire run = chip_en & synth_enable_bit;

  sd_modulator #(
    .ACC_W(FRAC_W)
  ) u_sd (
    .pclk(pclk),
    .presetn(presetn),
    .clear(~run),
    .advance(fb_end),
    .frac(n_frac),
    .carry(carry)
  );

  // count down integer modulus, plus one when the modulator carries
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ncnt_r <= 24'h0;
      fb_pulse_r <= 1'b0;
    end else if (!run) begin
      ncnt_r <= 24'h0;
      fb_pulse_r <= 1'b0;
    end else begin
      fb_pulse_r <= fb_end;
      if (fb_end) begin
        ncnt_r <= {15'h0, n_int - 9'h1 + {8'h0, carry}};
      end else if (vco_tick) begin
        ncnt_r <= ncnt_r - 24'h1;
      end
    end
  end

  // ============================================================
  // digital lock detect
  // small means strictly under the set threshold; one cycle is already too wide
  wire small_err = phase_err_valid & (phase_err_cycles < 8'(LOCK_SET_CYC));
  wire big_err = phase_err_valid & (phase_err_cycles >= 8'(LOCK_DROP_CYC));
  always_comb begin
    lock_st_nxt = lock_st_r;
    good_cnt_nxt = good_cnt_r;
    case (lock_st_r)
      LK_IDLE: begin
        if (small_err) begin
          lock_st_nxt = LK_COUNT;
          good_cnt_nxt = 3'h1;
        end
      end
      LK_COUNT: begin
        if (phase_err_valid && !small_err) begin
          lock_st_nxt = LK_IDLE;
          good_cnt_nxt = 3'h0;
        end else if (small_err) begin
          good_cnt_nxt = good_cnt_r + 3'h1;
          if (good_cnt_r == 3'(LOCK_COUNT - 1)) lock_st_nxt = LK_LOCKED;
        end
      end
      LK_LOCKED: begin
        if (big_err) begin
          lock_st_nxt = LK_IDLE;
          good_cnt_nxt = 3'h0;
        end
      end
      default: begin
        lock_st_nxt = LK_IDLE;
        good_cnt_nxt = 3'h0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_st_r <= LK_IDLE;
      good_cnt_r <= 3'h0;
      dig_lock_r <= 1'b0;
      ana_pulse_r <= 1'b0;
    end else if (!run) begin
      lock_st_r <= LK_IDLE;
      good_cnt_r <= 3'h0;
      dig_lock_r <= 1'b0;
      ana_pulse_r <= 1'b0;
    end else begin
      lock_st_r <= lock_st_nxt;
      good_cnt_r <= good_cnt_nxt;
      dig_lock_r <= (lock_st_nxt == LK_LOCKED);
      // analog form: one-cycle low pulse per nonzero error
      ana_pulse_r <= phase_err_valid & (phase_err_cycles != 8'h0);
    end
  end

  // ============================================================
  // status mux: oe low drives the pin; analog mode only ever drives low
  wire [2:0] mux_sel = divide_r[MUX_LSB +: MUX_W];
  wire mux_level = (mux_sel == MUX_DIG_LOCK) ? dig_lock_r :
                   (mux_sel == MUX_ANA_LOCK) ? ~ana_pulse_r :
                   reg_ready_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_r <= 1'b0;
      mux_oe_r <= 1'b0;
    end else begin
      mux_r <= (mux_sel == MUX_ANA_LOCK) ? 1'b0 : mux_level;
      mux_oe_r <= (mux_sel == MUX_ANA_LOCK) ? mux_level : 1'b0;
    end
  end
  assign status_mux_output_o = mux_r;
  assign status_mux_output_oe = mux_oe_r;

  // ============================================================
  // analog-side controls taken straight from registers
  assign cfg_r_vco_bias = {4'h0, osc_r[VBIAS_LSB +: VBIAS_W]};
  assign vco_enable = divide_r[SYNTH_EN_BIT];
  assign band_halving_bit = osc_r[BAND_HALF_BIT];
  assign vco_bias = cfg_r_vco_bias[3:0];
  assign vco_adjust = osc_r[VADJ_LSB +: VADJ_W];
  assign amp_enable_bit = tx_r[AMP_EN_BIT];
  assign pa_power = tx_r[PWR_LSB +: PWR_W];
  assign pa_bias = tx_r[PABIAS_LSB +: PABIAS_W];
  assign ref_clk_pulse = ref_pulse_r;
  assign fb_clk_pulse = fb_pulse_r;
  assign regulators_on = chip_en_r;

  // regulator enable follows chip enable, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) chip_en_r <= 1'b0;
    else chip_en_r <= chip_en;
  end
endmodule : synth_ctrl

// ### synth_ctrl_props.sv
// synth_ctrl_props: port-level checks of the synthesizer control block
// assumes it is bound onto synth_ctrl and the apb master holds each request
`timescale 1ns/1ps
module synth_ctrl_props
  import synth_pkg::*;
#(
  parameter int REG_READY_CYCLES = 1000,
  parameter int INT_W_P = 8
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic chip_en, // chip enable
  input wire logic xtal_tick, // crystal tick
  input wire logic vco_tick, // oscillator tick
  input wire logic phase_err_valid, // comparison done
  input wire logic [7:0] phase_err_cycles, // error width
  input wire logic ref_clk_pulse, // reference pulse
  input wire logic fb_clk_pulse, // feedback pulse
  input wire logic vco_enable, // loop on
  input wire logic band_halving_bit, // divide by two
  input wire logic [3:0] vco_bias, // oscillator bias
  input wire logic [1:0] vco_adjust, // oscillator recenter
  input wire logic amp_enable_bit, // output stage on
  input wire logic [5:0] pa_power, // power field
  input wire logic [1:0] pa_bias, // amplifier bias
  input wire logic regulators_on // regulators on
);
  logic [2:0] good_r;
  logic lk_r;
  logic [2:0] quiet_r;
  wire rd = pready && !pwrite && !pslverr;
  // ============================================================
  // reference lock model: five good comparisons set, one bad clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      good_r <= 3'h0;
      lk_r <= 1'b0;
      quiet_r <= 3'h0;
    end else if (!chip_en || !vco_enable) begin
      good_r <= 3'h0;
      lk_r <= 1'b0;
      quiet_r <= 3'h0;
    end else if (phase_err_valid) begin
      quiet_r <= 3'h0;
      good_r <= (phase_err_cycles != 8'h00) ? 3'h0 : (good_r == 3'h4) ? 3'h4 : good_r + 3'h1;
      lk_r <= (phase_err_cycles != 8'h00) ? 1'b0 : (lk_r || good_r == 3'h4);
    end else if (quiet_r != 3'h7) begin
      quiet_r <= quiet_r + 3'h1;
    end
  end
  // ============================================================
  // assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ce_off;
    !chip_en ##1 !chip_en;
  endsequence
  a_apb_answer: assert property (s_setup |=> pready)
    else $error("no ready in first access cycle");
  a_unmapped_err: assert property (pready && paddr > ADDR_STATUS |-> pslverr)
    else $error("unmapped access without error");
  a_tx_fields: assert property (rd && paddr == ADDR_TX |->
    pa_power == prdata[14:9] && pa_bias == prdata[31:30] && amp_enable_bit == prdata[4])
    else $error("transmit outputs differ from register");
  a_osc_fields: assert property (rd && paddr == ADDR_OSC |->
    band_halving_bit == prdata[13] && vco_bias == prdata[19:16] &&
    vco_adjust == prdata[21:20] && prdata[2:0] != 3'h0)
    else $error("oscillator outputs differ from register");
  a_div_limits: assert property (rd && paddr == ADDR_DIVIDE |->
    prdata[23:16] >= INT_MIN && !prdata[14] && vco_enable == prdata[28])
    else $error("divide word out of range");
  a_ce_wipe: assert property (s_ce_off |=> !regulators_on && !vco_enable &&
    !amp_enable_bit && pa_power == 6'h00 && vco_bias == 4'h0)
    else $error("config not wiped with chip enable low");
  a_lock_status: assert property (rd && paddr == ADDR_STATUS && quiet_r == 3'h7 |->
    prdata[2] == lk_r)
    else $error("lock status wrong");
  a_ref_tick: assert property (ref_clk_pulse |-> $past(xtal_tick))
    else $error("reference pulse without crystal tick");
  a_fb_tick: assert property (fb_clk_pulse |-> $past(vco_tick))
    else $error("feedback pulse without oscillator tick");
endmodule : synth_ctrl_props

bind synth_ctrl synth_ctrl_props #(.REG_READY_CYCLES(REG_READY_CYCLES), .INT_W_P(INT_W_P))
  u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .chip_en, .xtal_tick, .vco_tick, .phase_err_valid, .phase_err_cycles, .ref_clk_pulse,
  .fb_clk_pulse, .vco_enable, .band_halving_bit, .vco_bias, .vco_adjust, .amp_enable_bit,
  .pa_power, .pa_bias, .regulators_on);

// ### synth_pkg.sv
// synth_pkg: constants for the fractional synthesizer control block
// assumes 32-bit apb register words, one aligned word per register
package synth_pkg;
  // ============================================================
  // register byte addresses
  localparam logic [11:0] ADDR_DIVIDE = 12'h000;
  localparam logic [11:0] ADDR_OSC = 12'h004;
  localparam logic [11:0] ADDR_TX = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  // ============================================================
  // divide register fields
  localparam int FRAC_LSB = 0;
  localparam int FRAC_W = 15;
  localparam int INT_LSB = 16;
  localparam int INT_W = 8;
  localparam int SYNTH_EN_BIT = 28;
  localparam int MUX_LSB = 29;
  localparam int MUX_W = 3;
  // oscillator register fields
  localparam int RDIV_LSB = 0;
  localparam int RDIV_W = 3;
  localparam int BAND_HALF_BIT = 13;
  localparam int VBIAS_LSB = 16;
  localparam int VBIAS_W = 4;
  localparam int VADJ_LSB = 20;
  localparam int VADJ_W = 2;
  // transmit register fields
  localparam int AMP_EN_BIT = 4;
  localparam int MODSEL_LSB = 6;
  localparam int MODSEL_W = 3;
  localparam int PWR_LSB = 9;
  localparam int PWR_W = 6;
  localparam int MODNUM_LSB = 15;
  localparam int MODNUM_W = 9;
  localparam int PABIAS_LSB = 30;
  localparam int PABIAS_W = 2;
  // ============================================================
  // reset values and limits
  localparam logic [7:0] INT_MIN = 8'h1f;
  localparam logic [2:0] RDIV_RESET = 3'h1;
  localparam logic [2:0] MUX_REG_READY = 3'h0;
  localparam logic [2:0] MUX_DIG_LOCK = 3'h1;
  localparam logic [2:0] MUX_ANA_LOCK = 3'h2;
  localparam logic [2:0] MOD_FSK = 3'h0;
  localparam logic [31:0] DIVIDE_RESET = 32'h001f_0000;
  localparam logic [31:0] OSC_RESET = 32'h0000_0001;
  localparam logic [31:0] TX_RESET = 32'h0000_0000;
  // ============================================================
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int LOCK_SET_NS = 15;
  localparam int LOCK_DROP_NS = 25;
  localparam int LOCK_SET_CYC = (LOCK_SET_NS * CLK_HZ) / 1_000_000_000 > 0 ?
                                (LOCK_SET_NS * CLK_HZ) / 1_000_000_000 : 1;
  localparam int LOCK_DROP_CYC = (LOCK_DROP_NS * CLK_HZ + 999_999_999) / 1_000_000_000;
  localparam int LOCK_COUNT = 5;
  localparam int REG_READY_US = 50;
  localparam int REG_READY_CYC = REG_READY_US * (CLK_HZ / 1_000_000);
endpackage : synth_pkg
